// ---- src/swp_pkg.sv ----
// constants for the serial width and pin configuration block
package swp_pkg;
  localparam int unsigned ADDR_W        = 3;
  localparam logic [2:0]  OFF_CTRL_ONE  = 3'h0;
  localparam logic [2:0]  OFF_CTRL_TWO  = 3'h1;
  localparam logic [2:0]  OFF_STATUS    = 3'h3;
  localparam logic [2:0]  OFF_MASK      = 3'h4;
  localparam logic [7:0]  CTRL_TWO_RST  = 8'h00;
  localparam logic [7:0]  CTRL_TWO_MASK = 8'h5b;
  localparam logic [7:0]  CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0]  CTRL_ONE_MASK = 8'h12;
  localparam logic [7:0]  IRQ_MASK_RST  = 8'h00;
  // serial_control_two fields
  localparam int unsigned BIT_WIDTH     = 6;
  localparam int unsigned BIT_MODE_FAULT_FLAG_EN   = 4;
  localparam int unsigned BIT_BIDIR_OE  = 3;
  localparam int unsigned BIT_WAIT_STOP = 1;
  localparam int unsigned BIT_BIDIR     = 0;
  // own control register fields
  localparam int unsigned BIT_MASTER    = 4;
  localparam int unsigned BIT_SEL_OE    = 1;
  // status fields
  localparam int unsigned ST_ABORT      = 0;
  localparam int unsigned ST_MODE_FAULT = 1;
endpackage

// ---- src/swp_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module swp_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- src/swp_top.sv ----
// serial width and pin configuration control with pin routing
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module swp_top
  import swp_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // register port
  input  wire logic [swp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [7:0]                reg_rdata,
  output logic                           irq,
  // transfer engine side
  input  wire logic                      engine_busy,
  input  wire logic                      engine_sclk,
  input  wire logic                      engine_dout,
  input  wire logic                      engine_sel_n,
  input  wire logic                      wait_mode,
  output logic                           abort_idle,
  output logic                           wide_transfer,
  output logic                           data_high_used,
  output logic                           engine_din,
  output logic                           sclk_run,
  output logic                           mode_fault_flag,
  // serial pins
  output logic                           sclk_o,
  input  wire logic                      mosi_i,
  output logic                           mosi_o,
  output logic                           mosi_oe,
  input  wire logic                      miso_i,
  output logic                           miso_o,
  output logic                           miso_oe,
  input  wire logic                      sel_n_i,
  output logic                           sel_n_o,
  output logic                           sel_n_oe
);
  import swp_pkg::*;

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [2:0] pins_s;
  logic       mosi_s;
  logic       miso_s;
  logic       sel_n_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  swp_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({mosi_i, miso_i, ~sel_n_i}),
    .q     (pins_s)
  );
  assign mosi_s  = pins_s[2];
  assign miso_s  = pins_s[1];
  // inverted through the flops so select reads idle high out of reset
  assign sel_n_s = ~pins_s[0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_two_q;
  logic [7:0] ctrl_one_q;
  logic [7:0] mask_q;
  logic [7:0] status_q;
  logic [7:0] ctrl_two_d;
  logic       wr_two;
  logic       wr_one;
  logic       is_master;
  logic       bidir;
  logic       bidir_oe;
  logic       mode_fault_flag_en;
  logic       sel_oe;

  assign wr_two     = reg_write && (reg_addr == OFF_CTRL_TWO);
  assign wr_one     = reg_write && (reg_addr == OFF_CTRL_ONE);
  assign ctrl_two_d = reg_wdata & CTRL_TWO_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two_q <= CTRL_TWO_RST;
    end else if (wr_two) begin
      ctrl_two_q <= ctrl_two_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_q <= CTRL_ONE_RST;
    end else if (wr_one) begin
      ctrl_one_q <= reg_wdata & CTRL_ONE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= IRQ_MASK_RST;
    end else if (reg_write && (reg_addr == OFF_MASK)) begin
      mask_q <= reg_wdata;
    end
  end

  assign is_master = ctrl_one_q[BIT_MASTER];
  assign sel_oe    = ctrl_one_q[BIT_SEL_OE];
  assign bidir     = ctrl_two_q[BIT_BIDIR];
  assign bidir_oe  = ctrl_two_q[BIT_BIDIR_OE];
  assign mode_fault_flag_en   = ctrl_two_q[BIT_MODE_FAULT_FLAG_EN];

  // ---------------------------------------------------------------
  // abort on configuration change
  // ---------------------------------------------------------------
  logic chg_main;
  logic chg_oe;
  logic abort_d;
  logic abort_q;

  assign chg_main = (ctrl_two_d[BIT_WIDTH]   != ctrl_two_q[BIT_WIDTH])
                 || (ctrl_two_d[BIT_MODE_FAULT_FLAG_EN] != mode_fault_flag_en)
                 || (ctrl_two_d[BIT_BIDIR]   != bidir);
  assign chg_oe   = bidir && (ctrl_two_d[BIT_BIDIR_OE] != bidir_oe);
  assign abort_d  = wr_two && is_master && (chg_main || chg_oe);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end
  assign abort_idle = abort_q;

  // ---------------------------------------------------------------
  // width and clock gating
  // ---------------------------------------------------------------
  logic run_q;

  assign wide_transfer  = ctrl_two_q[BIT_WIDTH];
  assign data_high_used = ctrl_two_q[BIT_WIDTH];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= 1'b1;
      sclk_o <= 1'b0;
    end else begin
      run_q  <= !(wait_mode && ctrl_two_q[BIT_WAIT_STOP]);
      sclk_o <= is_master && engine_sclk
             && !(wait_mode && ctrl_two_q[BIT_WAIT_STOP]);
    end
  end
  assign sclk_run = run_q;

  // ---------------------------------------------------------------
  // data pin routing
  // ---------------------------------------------------------------
  logic din_d;
  logic mosi_oe_d;
  logic miso_oe_d;
  logic sel_oe_d;

  always_comb begin
    if (is_master) begin
      mosi_oe_d = !bidir || bidir_oe;
      miso_oe_d = 1'b0;
      din_d     = bidir ? mosi_s : miso_s;
    end else begin
      miso_oe_d = (!bidir || bidir_oe) && !sel_n_s;
      mosi_oe_d = 1'b0;
      din_d     = bidir ? miso_s : mosi_s;
    end
  end

  assign sel_oe_d = is_master && mode_fault_flag_en && sel_oe;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mosi_oe    <= 1'b0;
      miso_oe    <= 1'b0;
      sel_n_oe   <= 1'b0;
      mosi_o     <= 1'b0;
      miso_o     <= 1'b0;
      sel_n_o    <= 1'b1;
      engine_din <= 1'b0;
    end else begin
      mosi_oe    <= mosi_oe_d;
      miso_oe    <= miso_oe_d;
      sel_n_oe   <= sel_oe_d;
      mosi_o     <= engine_dout;
      miso_o     <= engine_dout;
      sel_n_o    <= engine_sel_n;
      engine_din <= din_d;
    end
  end

  // ---------------------------------------------------------------
  // status, mode fault and interrupt
  // ---------------------------------------------------------------
  logic fault_evt;
  logic rd_status;
  logic [7:0] set_bits;

  assign fault_evt = is_master && mode_fault_flag_en && !sel_oe && !sel_n_s;
  assign rd_status = reg_read && (reg_addr == OFF_STATUS);
  always_comb begin
    set_bits                = 8'h00;
    set_bits[ST_ABORT]      = abort_d && engine_busy;
    set_bits[ST_MODE_FAULT] = fault_evt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else if (rd_status) begin
      status_q <= set_bits; // set wins over read clear
    end else begin
      status_q <= status_q | set_bits;
    end
  end
  assign mode_fault_flag = status_q[ST_MODE_FAULT];
  assign irq             = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_read) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == OFF_CTRL_TWO) begin
      reg_rdata <= ctrl_two_q;
    end else if (reg_addr == OFF_CTRL_ONE) begin
      reg_rdata <= ctrl_one_q;
    end else if (reg_addr == OFF_STATUS) begin
      reg_rdata <= status_q;
    end else if (reg_addr == OFF_MASK) begin
      reg_rdata <= mask_q;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_abort_on_change: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_two && is_master
     && (ctrl_two_d[BIT_WIDTH] != ctrl_two_q[BIT_WIDTH]))
    |=> abort_idle)
    else $error("width change in master did not abort");
  a_abort_pin_change: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_two && is_master && ((ctrl_two_d[BIT_MODE_FAULT_FLAG_EN] != mode_fault_flag_en)
     || (ctrl_two_d[BIT_BIDIR] != bidir)))
    |=> abort_idle)
    else $error("pin control change in master did not abort");
  a_abort_oe_change: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_two && is_master && bidir
     && (ctrl_two_d[BIT_BIDIR_OE] != bidir_oe))
    |=> abort_idle)
    else $error("output enable change did not abort");
  a_no_abort_slave: assert property (
    @(posedge clk) disable iff (!rst_n)
    !is_master |=> !abort_idle)
    else $error("abort raised in slave mode");
  a_fault_gated: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!mode_fault_flag_en && !$past(mode_fault_flag_en) && rd_status) |=> !mode_fault_flag)
    else $error("mode fault set while disabled");
  a_fault_held_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!mode_fault_flag_en && !mode_fault_flag) |=> !mode_fault_flag)
    else $error("mode fault raised while disabled");
  a_fault_raised: assert property (
    @(posedge clk) disable iff (!rst_n)
    fault_evt |=> mode_fault_flag)
    else $error("select input low did not raise mode fault");
  a_sel_unused: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!mode_fault_flag_en || !is_master) |=> !sel_n_oe)
    else $error("select pin driven when unused");
  a_sel_output: assert property (
    @(posedge clk) disable iff (!rst_n)
    (is_master && mode_fault_flag_en && sel_oe) |=> sel_n_oe)
    else $error("select output not enabled");
  a_master_miso_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    is_master |=> !miso_oe)
    else $error("master drove miso");
  a_slave_mosi_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    !is_master |=> !mosi_oe)
    else $error("slave drove mosi");
  a_master_mosi_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    (is_master && !bidir) |=> mosi_oe)
    else $error("master did not drive mosi");
  a_slave_bidir_in: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!is_master && bidir && !bidir_oe) |=> !miso_oe)
    else $error("slave drove miso while oe clear");
  a_master_bidir_in: assert property (
    @(posedge clk) disable iff (!rst_n)
    (is_master && bidir) |=> (engine_din == $past(mosi_s)))
    else $error("master bidir input not taken from mosi");
  a_bidir_oe_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    (is_master && bidir && !bidir_oe) |=> !mosi_oe)
    else $error("bidir buffer enabled while oe clear");
  a_wait_stop: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wait_mode && ctrl_two_q[BIT_WAIT_STOP]) |=> (!sclk_run && !sclk_o))
    else $error("serial clock ran in wait stop");
  a_wait_run: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ctrl_two_q[BIT_WAIT_STOP] |=> sclk_run)
    else $error("serial clock stopped without wait stop");
  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_two |=> ((ctrl_two_q & ~CTRL_TWO_MASK) == 8'h00))
    else $error("reserved control bits set");
  a_width_out: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_two |=> (wide_transfer == $past(reg_wdata[BIT_WIDTH])))
    else $error("width select not applied");
endmodule
`default_nettype wire

// ---- bench/swp_peer.sv ----
// spi peer model resolving the serial data and select lines
`timescale 1ns/1ps
`default_nettype none
module swp_peer (
  // device side of the pins
  input  wire logic mosi_o,
  input  wire logic mosi_oe,
  input  wire logic miso_o,
  input  wire logic miso_oe,
  input  wire logic sel_n_o,
  input  wire logic sel_n_oe,
  // peer controls
  input  wire logic peer_bit,
  input  wire logic sel_low,
  // resolved lines
  output logic      mosi_w,
  output logic      miso_w,
  output logic      sel_n_w
);
  // peer drives opposite levels on the two data lines to tell them apart
  assign miso_w  = miso_oe ? miso_o : peer_bit;
  assign mosi_w  = mosi_oe ? mosi_o : ~peer_bit;
  assign sel_n_w = sel_n_oe ? sel_n_o : ~sel_low;
endmodule
`default_nettype wire

// ---- bench/swp_top_tb.sv ----
// self-checking bench for the width and pin configuration block
`timescale 1ns/1ps
`default_nettype none
module swp_top_tb;
  import swp_pkg::*;
  logic       clk, reset_n, reg_write, reg_read, busy, sclk, dout, esel_n;
  logic       wmode, pbit, sel_low, mosi_w, miso_w, sel_n_w;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, d, v, old;
  logic [31:0] seed;
  int         failures, checks_done;
  wire logic [7:0] rdata;
  wire logic  irq, abort, wide, high, din, srun, mf, sclk_o;
  wire logic  mosi_o, mosi_oe, miso_o, miso_oe, sel_n_o, sel_n_oe;
  logic [7:0] vals [8] = '{8'h40, 8'h40, 8'h50, 8'h51, 8'h59, 8'h5b,
                           8'h50, 8'h58};
  swp_top dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(rdata), .irq(irq), .engine_busy(busy), .engine_sclk(sclk),
    .engine_dout(dout), .engine_sel_n(esel_n), .wait_mode(wmode),
    .abort_idle(abort), .wide_transfer(wide), .data_high_used(high),
    .engine_din(din), .sclk_run(srun), .mode_fault_flag(mf),
    .sclk_o(sclk_o), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .sel_n_i(sel_n_w), .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe));
  swp_peer peer_u (.mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_o(miso_o),
    .miso_oe(miso_oe), .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe),
    .peer_bit(pbit), .sel_low(sel_low), .mosi_w(mosi_w),
    .miso_w(miso_w), .sel_n_w(sel_n_w));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // abort expected from a master rewrite of control two
  function automatic logic ab(input logic [7:0] o, input logic [7:0] n);
    return |((o ^ n) & (8'h51 | (o[0] ? 8'h08 : 8'h00)));
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    r = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog and scenarios
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200us;
    failures++;
    tally_and_finish();
  end
  initial begin
    {reset_n, reg_write, reg_read, busy, sclk, dout, wmode} = '0;
    {esel_n, pbit, sel_low} = 3'b100;
    reg_addr = '0;
    reg_wdata = '0;
    seed = 32'h231a;
    failures = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wt(3);
    rd(OFF_CTRL_TWO, d);
    chk(d, CTRL_TWO_RST);
    chk(8'(wide), 8'h00);
    rd(3'h6, d);
    chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'hff : (i == 1) ? 8'ha4 : seed[7:0];
      wr(OFF_CTRL_TWO, v);
      chk(8'({wide, high}), 8'({v[6], v[6]}));
      rd(OFF_CTRL_TWO, d);
      chk(d, v & CTRL_TWO_MASK);
    end
    wr(OFF_CTRL_ONE, 8'h10);
    wr(OFF_CTRL_TWO, 8'h00);
    old = 8'h00;
    busy <= 1'b1;
    foreach (vals[i]) begin
      wr(OFF_CTRL_TWO, vals[i]);
      chk(8'(abort), 8'(ab(old, vals[i])));
      old = vals[i];
    end
    wr(OFF_CTRL_ONE, 8'h00);
    wr(OFF_CTRL_TWO, 8'h11);
    chk(8'(abort), 8'h00);
    busy <= 1'b0;
    sel_low <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pbit <= seed[0];
      dout <= seed[1];
      wr(OFF_CTRL_ONE, i[2] ? 8'h10 : 8'h00);
      wr(OFF_CTRL_TWO, {4'h0, i[0], 2'b00, i[1]});
      wt(6);
      chk(8'({mosi_oe, miso_oe}), i[2] ? (i[1] ? 8'({i[0], 1'b0}) : 8'h2)
          : (i[1] ? 8'(i[0]) : 8'h1));
      if (!(i[1] && i[0]))
        chk(8'(din), 8'(pbit ^ (i[2] == i[1])));
      chk(8'(sel_n_oe), 8'h00);
      chk(8'({mosi_o, miso_o}), 8'({dout, dout}));
    end
    sel_low <= 1'b0;
    wr(OFF_CTRL_ONE, 8'h12);
    wr(OFF_CTRL_TWO, 8'h10);
    esel_n <= 1'b0;
    wt(6);
    chk(8'({sel_n_oe, sel_n_o}), 8'h2);
    wr(OFF_CTRL_ONE, 8'h02);
    wt(4);
    chk(8'(sel_n_oe), 8'h00);
    wr(OFF_MASK, 8'h02);
    wr(OFF_CTRL_ONE, 8'h10);
    wr(OFF_CTRL_TWO, 8'h00);
    sel_low <= 1'b1;
    wt(6);
    chk(8'({mf, irq}), 8'h0);
    wr(OFF_CTRL_TWO, 8'h10);
    wt(6);
    chk(8'({mf, irq}), 8'h3);
    sel_low <= 1'b0;
    wt(6);
    rd(OFF_STATUS, d);
    chk(d & 8'h02, 8'h02);
    wt(1);
    chk(8'({mf, irq}), 8'h0);
    wr(OFF_CTRL_TWO, 8'h02);
    sel_low <= 1'b1;
    wt(4);
    rd(OFF_STATUS, d);
    chk(d & 8'h02, 8'h00);
    sclk <= 1'b1;
    wmode <= 1'b1;
    wt(4);
    chk(8'({srun, sclk_o}), 8'h0);
    wmode <= 1'b0;
    wt(4);
    chk(8'({srun, sclk_o}), 8'h3);
    wr(OFF_CTRL_TWO, 8'h00);
    wmode <= 1'b1;
    wt(4);
    chk(8'(srun), 8'h1);
    wr(OFF_CTRL_TWO, 8'h5b);
    reset_n <= 1'b0;
    wt(2);
    reset_n <= 1'b1;
    wt(3);
    rd(OFF_CTRL_TWO, d);
    chk(d, CTRL_TWO_RST);
    chk(8'({wide, srun}), 8'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
